// ### hw/sscr_regs.sv
// Register bank: fault, identity, charge config, charge status, scaling
`timescale 1ns/1ps
module sscr_regs
#(
  // Identity strings: byte 0 in the top byte; all values arbitrary
  parameter logic [47:0] MAKER_HEAD = 48'h51_52_53_54_55_56,
  parameter logic [47:0] MAKER_TAIL = 48'h59_5a_20_20_20_20,
  parameter logic [47:0] MODEL_HEAD = 48'h53_59_53_2e_37_36,
  parameter logic [47:0] MODEL_TAIL = 48'h2e_31_20_20_20_20,
  parameter logic [47:0] REVISIONS = 48'h15_ff_ff_ff_ff_ff,
  parameter logic [47:0] BUILD_DATE = 48'h31_37_31_31_31_38,
  parameter logic [47:0] SERIAL_TAIL = 48'h31_36_38_31_39_37,
  // Scale bytes 0..5, byte 0 in the top byte; each nibble 0 or 4..9
  parameter logic [47:0] SCALE_MAP = 48'h55_06_06_00_00_00
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic resp_valid,
  output logic resp_error,
  output logic [15:0] resp_data,
  input wire logic over_temp,
  input wire logic over_voltage_trip,
  input wire logic over_current_trip,
  input wire logic short_circuit,
  input wire logic mains_out_of_range,
  input wire logic dc_output_disabled,
  input wire logic internal_heat_alarm,
  input wire logic charge_complete,
  input wire logic in_const_current,
  input wire logic in_const_voltage,
  input wire logic in_float_stage,
  input wire logic temp_sense_shorted,
  input wire logic battery_absent,
  input wire logic const_current_timed_out,
  input wire logic const_voltage_timed_out,
  input wire logic float_timed_out,
  output logic [1:0] curve_select,
  output logic [1:0] temp_comp_slope,
  output logic stage_count_select,
  output logic charger_mode_enable,
  output logic const_current_timeout_enable,
  output logic const_voltage_timeout_enable,
  output logic float_timeout_enable
);
  import sscr_pkg::*;

  localparam int NSYNC = STATUS_INPUTS + 2;

  logic [NSYNC-1:0] raw_status;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [15:0] config_word;
  logic [15:0] fault_word;
  logic [15:0] charge_word;
  logic [15:0] next_rdata;
  logic hit;
  logic wr_config;

  assign raw_status = {float_timed_out, const_voltage_timed_out, const_current_timed_out,
    battery_absent, temp_sense_shorted, in_float_stage, in_const_voltage,
    in_const_current, charge_complete, internal_heat_alarm, dc_output_disabled,
    mains_out_of_range, short_circuit, over_current_trip, over_voltage_trip, over_temp};

  // Status pins come from the power stage, outside this clock domain
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge clock)
      begin
        if (!reset_n)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end
        else
        begin
          sync_a[gi] <= raw_status[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  // Live level flags; no latching, each bit clears when its cause goes away
  always_comb
  begin
    fault_word = 16'h0000;
    fault_word[FLT_OVER_TEMP] = sync_b[0];
    fault_word[FLT_OVER_VOLT] = sync_b[1];
    fault_word[FLT_OVER_CURR] = sync_b[2];
    fault_word[FLT_SHORT] = sync_b[3];
    fault_word[FLT_MAINS] = sync_b[4];
    fault_word[FLT_DC_OFF] = sync_b[5];
    fault_word[FLT_HEAT] = sync_b[6];
  end

  // Charger flags mean nothing in plain supply mode, so they read zero there
  always_comb
  begin
    charge_word = 16'h0000;
    if (config_word[CFG_CHARGER])
    begin
      charge_word[CHG_COMPLETE] = sync_b[7];
      charge_word[CHG_CC] = sync_b[8];
      charge_word[CHG_CV] = sync_b[9];
      charge_word[CHG_FLOAT] = sync_b[10];
      charge_word[CHG_SENSE_SHORT] = sync_b[11];
      charge_word[CHG_NO_BATTERY] = sync_b[12];
      charge_word[CHG_CC_TIMEOUT] = sync_b[13] & config_word[CFG_CC_TO_EN];
      charge_word[CHG_CV_TIMEOUT] = sync_b[14] & config_word[CFG_CV_TO_EN];
      charge_word[CHG_FV_TIMEOUT] = sync_b[15] & config_word[CFG_FV_TO_EN];
    end
  end

  function automatic logic [15:0] group_word(input logic [47:0] grp, input logic [15:0] idx);
    logic [15:0] w;
    w = 16'h0000;
    unique case (idx)
      16'h0000: w = grp[47:32];
      16'h0001: w = grp[31:16];
      16'h0002: w = grp[15:0];
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  function automatic logic in_group(input logic [15:0] a, input logic [15:0] base);
    return (a >= base) && (a < base + GROUP_REGS);
  endfunction

  // Read decode; hit also marks the only addresses that answer without exception
  always_comb
  begin
    next_rdata = 16'h0000;
    hit = 1'b1;
    if (req_addr == ADDR_FAULT)
      next_rdata = fault_word;
    else if (in_group(req_addr, ADDR_MAKER_HEAD))
      next_rdata = group_word(MAKER_HEAD, req_addr - ADDR_MAKER_HEAD);
    else if (in_group(req_addr, ADDR_MAKER_TAIL))
      next_rdata = group_word(MAKER_TAIL, req_addr - ADDR_MAKER_TAIL);
    else if (in_group(req_addr, ADDR_MODEL_HEAD))
      next_rdata = group_word(MODEL_HEAD, req_addr - ADDR_MODEL_HEAD);
    else if (in_group(req_addr, ADDR_MODEL_TAIL))
      next_rdata = group_word(MODEL_TAIL, req_addr - ADDR_MODEL_TAIL);
    else if (in_group(req_addr, ADDR_REVISION))
      next_rdata = group_word(REVISIONS, req_addr - ADDR_REVISION);
    else if (in_group(req_addr, ADDR_BUILD_DATE))
      next_rdata = group_word(BUILD_DATE, req_addr - ADDR_BUILD_DATE);
    else if (in_group(req_addr, ADDR_SERIAL_HEAD))
      next_rdata = group_word(BUILD_DATE, req_addr - ADDR_SERIAL_HEAD);
    else if (in_group(req_addr, ADDR_SERIAL_TAIL))
      next_rdata = group_word(SERIAL_TAIL, req_addr - ADDR_SERIAL_TAIL);
    else if (req_addr == ADDR_CONFIG)
      next_rdata = config_word;
    else if (req_addr == ADDR_CHARGE)
      next_rdata = charge_word;
    else if (in_group(req_addr, ADDR_SCALE))
      next_rdata = group_word(SCALE_MAP, req_addr - ADDR_SCALE);
    else
      hit = 1'b0;
  end

  // Only the config word is writable; unsupported bits are masked to zero
  assign wr_config = req_valid && req_write && (req_addr == ADDR_CONFIG);

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      config_word <= CFG_RESET;
    else if (wr_config)
      config_word <= req_wdata & CFG_WRITE_MASK;
  end

  // One answer per request, the cycle after it; a config write echoes its masked data, a refused write returns zero
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      resp_valid <= 1'b0;
      resp_error <= 1'b0;
      resp_data <= 16'h0000;
    end
    else
    begin
      resp_valid <= req_valid;
      if (req_valid && req_write)
      begin
        resp_error <= !wr_config;
        resp_data <= wr_config ? (req_wdata & CFG_WRITE_MASK) : 16'h0000;
      end
      else if (req_valid)
      begin
        resp_error <= !hit;
        resp_data <= hit ? next_rdata : 16'h0000;
      end
      else
      begin
        resp_error <= 1'b0;
        resp_data <= 16'h0000;
      end
    end
  end

  // Charger controls are registered copies of the config flops, one cycle behind them
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      curve_select <= CFG_RESET[CFG_CURVE_LSB +: 2];
      temp_comp_slope <= CFG_RESET[CFG_SLOPE_LSB +: 2];
      stage_count_select <= CFG_RESET[CFG_STAGES];
      charger_mode_enable <= CFG_RESET[CFG_CHARGER];
      const_current_timeout_enable <= CFG_RESET[CFG_CC_TO_EN];
      const_voltage_timeout_enable <= CFG_RESET[CFG_CV_TO_EN];
      float_timeout_enable <= CFG_RESET[CFG_FV_TO_EN];
    end
    else
    begin
      curve_select <= config_word[CFG_CURVE_LSB +: 2];
      temp_comp_slope <= config_word[CFG_SLOPE_LSB +: 2];
      stage_count_select <= config_word[CFG_STAGES];
      charger_mode_enable <= config_word[CFG_CHARGER];
      const_current_timeout_enable <= config_word[CFG_CC_TO_EN];
      const_voltage_timeout_enable <= config_word[CFG_CV_TO_EN];
      float_timeout_enable <= config_word[CFG_FV_TO_EN];
    end
  end
endmodule

// ### hw/sscr_pkg.sv
// Constants of the supply status and charger register bank
// Function
// - Fault bit 1 follows internal over-temperature.
// - Fault bit 2 follows output over-voltage protection.
// - Fault bit 3 follows output over-current protection.
// - Fault bit 4 follows short-circuit protection.
// - Fault bit 5 flags mains input outside normal range.
// - Fault bit 6 is 1 while DC output is off.
// - Fault bit 7 follows internal high-temperature alarm.
// - Unused and unsupported bits of fault, config and charge status read zero.
// - Maker name is 12 ASCII bytes in registers 0x80..0x85, space padded.
// - Model name is 12 ASCII bytes in registers 0x86..0x8b.
// - Revision group holds one byte per controller; 0xff marks absent one.
// - Build date is six ASCII digits year, month, day at 0x91.
// - Serial groups hold six-digit date at 0x94, serial number at 0x97.
// - Config bits 1:0 select charge curve, default customised.
// - Config bits 3:2 set temperature compensation slope, default 01.
// - Config bit 6 picks two-stage or three-stage charging, default three.
// - Config bit 7 enables charger mode, default power-supply mode.
// - Config high bits 0..2 enable stage timeout indication, default off.
// - Charge status low bits 0..3: complete, const current, const voltage, float.
// - Charge status bit 10 sense short, bit 11 battery absent.
// - Charge status bits 13..15 flag stage timeouts.
// - Scaling nibbles: 0 unsupported, 4..9 decades, a..f reserved.
// - Scaling bytes pack factors, first-named factor in low nibble.
package sscr_pkg;
  localparam logic [15:0] ADDR_FAULT = 16'h0040;
  localparam logic [15:0] ADDR_MAKER_HEAD = 16'h0080;
  localparam logic [15:0] ADDR_MAKER_TAIL = 16'h0083;
  localparam logic [15:0] ADDR_MODEL_HEAD = 16'h0086;
  localparam logic [15:0] ADDR_MODEL_TAIL = 16'h0089;
  localparam logic [15:0] ADDR_REVISION = 16'h008c;
  localparam logic [15:0] ADDR_BUILD_DATE = 16'h0091;
  localparam logic [15:0] ADDR_SERIAL_HEAD = 16'h0094;
  localparam logic [15:0] ADDR_SERIAL_TAIL = 16'h0097;
  localparam logic [15:0] ADDR_CONFIG = 16'h00b4;
  localparam logic [15:0] ADDR_CHARGE = 16'h00b8;
  localparam logic [15:0] ADDR_SCALE = 16'h00c0;
  // Every 48-bit group spans three consecutive 16-bit registers
  localparam logic [15:0] GROUP_REGS = 16'h0003;
  // Fault word bit positions
  localparam int FLT_OVER_TEMP = 1;
  localparam int FLT_OVER_VOLT = 2;
  localparam int FLT_OVER_CURR = 3;
  localparam int FLT_SHORT = 4;
  localparam int FLT_MAINS = 5;
  localparam int FLT_DC_OFF = 6;
  localparam int FLT_HEAT = 7;
  // Config word fields
  localparam int CFG_CURVE_LSB = 0;
  localparam int CFG_SLOPE_LSB = 2;
  localparam int CFG_STAGES = 6;
  localparam int CFG_CHARGER = 7;
  localparam int CFG_CC_TO_EN = 8;
  localparam int CFG_CV_TO_EN = 9;
  localparam int CFG_FV_TO_EN = 10;
  localparam logic [15:0] CFG_RESET = 16'h0004;
  localparam logic [15:0] CFG_WRITE_MASK = 16'h07cf;
  // Charge status bit positions
  localparam int CHG_COMPLETE = 0;
  localparam int CHG_CC = 1;
  localparam int CHG_CV = 2;
  localparam int CHG_FLOAT = 3;
  localparam int CHG_SENSE_SHORT = 10;
  localparam int CHG_NO_BATTERY = 11;
  localparam int CHG_CC_TIMEOUT = 13;
  localparam int CHG_CV_TIMEOUT = 14;
  localparam int CHG_FV_TIMEOUT = 15;
  localparam int STATUS_INPUTS = 14;
endpackage

// ### dv/sscr_regs_assertions.sv
// Port checks of the supply status register bank
`timescale 1ns/1ps
module sscr_regs_checker
  import sscr_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic resp_valid,
  input wire logic resp_error,
  input wire logic [15:0] resp_data,
  input wire logic over_voltage_trip,
  input wire logic dc_output_disabled,
  input wire logic [1:0] curve_select,
  input wire logic charger_mode_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire rd = req_valid && !req_write;
  wire wr_cfg = req_valid && req_write && req_addr == ADDR_CONFIG;
  property p_wr_refused;
    req_valid && req_write && req_addr != ADDR_CONFIG |=> resp_valid && resp_error && resp_data == 16'h0000;
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("write not refused");
  property p_fault_zero;
    rd && req_addr == ADDR_FAULT |=> resp_data[15:8] == 8'h00 && !resp_data[0];
  endproperty
  a_fault_zero: assert property (p_fault_zero) else $error("fault spare bits set");
  property p_ovp;
    over_voltage_trip [*4] ##0 rd && req_addr == ADDR_FAULT |=> resp_data[2];
  endproperty
  a_ovp: assert property (p_ovp) else $error("over-voltage bit missing");
  property p_dc_on;
    !dc_output_disabled [*4] ##0 rd && req_addr == ADDR_FAULT |=> !resp_data[6];
  endproperty
  a_dc_on: assert property (p_dc_on) else $error("output-off bit wrong");
  property p_enable;
    wr_cfg |-> ##2 charger_mode_enable == $past(req_wdata[7], 2);
  endproperty
  a_enable: assert property (p_enable) else $error("charger enable wrong");
  property p_curve;
    wr_cfg |-> ##2 curve_select == $past(req_wdata[1:0], 2);
  endproperty
  a_curve: assert property (p_curve) else $error("curve select wrong");
  property p_cfg_zero;
    rd && req_addr == ADDR_CONFIG |=> resp_data[15:11] == 5'h00 && resp_data[5:4] == 2'h0;
  endproperty
  a_cfg_zero: assert property (p_cfg_zero) else $error("config spare bits set");
  property p_chg_off;
    rd && req_addr == ADDR_CHARGE ##1 !charger_mode_enable |-> resp_data == 16'h0000;
  endproperty
  a_chg_off: assert property (p_chg_off) else $error("charge status in supply mode");
endmodule
bind sscr_regs sscr_regs_checker i_sscr_regs_checker (.clock, .reset_n, .req_valid, .req_write,
  .req_addr, .req_wdata, .resp_valid, .resp_error, .resp_data, .over_voltage_trip,
  .dc_output_disabled, .curve_select, .charger_mode_enable);

// ### dv/sscr_master_model.sv
// Serial bus master model issuing one register request at a time
`timescale 1ns/1ps
module sscr_master_model
(
  input wire logic clock,
  output logic req_valid,
  output logic req_write,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata,
  input wire logic resp_valid,
  input wire logic resp_error,
  input wire logic [15:0] resp_data
);
  initial
  begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
  end
  // Readings are handed back raw; applying the scale map is software's job
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] wd,
    output logic [15:0] d, output logic e);
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= wd;
    @(posedge clock);
    req_valid <= 1'b0;
    // Idle address and data lines never keep the last value, so stale decode cannot pass
    req_addr <= ~a;
    req_wdata <= ~wd;
    #1;
    d = resp_valid === 1'b1 ? resp_data : 16'hxxxx;
    e = resp_error;
  endtask
endmodule

// ### dv/testbench.sv
// Self-checking bench of the supply status register bank
`timescale 1ns/1ps
module testbench;
  import sscr_pkg::*;
  logic clock, reset_n, req_valid, req_write, resp_valid, resp_error;
  logic [15:0] req_addr, req_wdata, resp_data;
  logic [6:0] flt;
  logic [8:0] chg;
  logic [1:0] curve, slope;
  logic stg, cme, cto, cvto, fto;
  int bad_count, total_checks;
  int cycles = 0;
  sscr_regs #(.MAKER_HEAD(48'h56_55_54_53_52_51), .MAKER_TAIL(48'h58_59_20_20_20_20),
    .MODEL_HEAD(48'h5a_59_2e_37_36_31), .MODEL_TAIL(48'h2e_39_20_20_20_20),
    .REVISIONS(48'hfe_69_ff_ff_ff_ff),
    .BUILD_DATE(48'h31_39_31_31_31_36), .SERIAL_TAIL(48'h39_31_36_38_37_31),
    .SCALE_MAP(48'h65_07_06_00_00_00)) i_sscr_regs (.clock, .reset_n, .req_valid, .req_write,
    .req_addr, .req_wdata, .resp_valid, .resp_error, .resp_data, .over_temp(flt[0]),
    .over_voltage_trip(flt[1]), .over_current_trip(flt[2]), .short_circuit(flt[3]),
    .mains_out_of_range(flt[4]), .dc_output_disabled(flt[5]), .internal_heat_alarm(flt[6]),
    .charge_complete(chg[0]), .in_const_current(chg[1]), .in_const_voltage(chg[2]),
    .in_float_stage(chg[3]), .temp_sense_shorted(chg[4]), .battery_absent(chg[5]),
    .const_current_timed_out(chg[6]), .const_voltage_timed_out(chg[7]),
    .float_timed_out(chg[8]), .curve_select(curve), .temp_comp_slope(slope),
    .stage_count_select(stg), .charger_mode_enable(cme), .const_current_timeout_enable(cto),
    .const_voltage_timeout_enable(cvto), .float_timeout_enable(fto));
  sscr_master_model i_sscr_master_model (.clock, .req_valid, .req_write, .req_addr,
    .req_wdata, .resp_valid, .resp_error, .resp_data);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic give_verdict();
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] wd,
    input logic [15:0] exp, input logic err);
    logic [15:0] d;
    logic e;
    i_sscr_master_model.xfer(w, a, wd, d, e);
    chk(d, exp);
    chk({15'h0000, e}, {15'h0000, err});
  endtask
  task automatic t_ident();
    logic [15:0] ia [0:13];
    logic [15:0] ie [0:13];
    ia = '{16'h0080, 16'h0083, 16'h0085, 16'h0086, 16'h0089, 16'h008c, 16'h008e, 16'h0091,
      16'h0093, 16'h0094, 16'h0099, 16'h00c0, 16'h00c1, 16'h0041};
    ie = '{16'h5655, 16'h5859, 16'h2020, 16'h5a59, 16'h2e39, 16'hfe69, 16'hffff, 16'h3139,
      16'h3136, 16'h3139, 16'h3731, 16'h6507, 16'h0600, 16'h0000};
    for (int i = 0; i < 14; i++)
      acc(1'b0, ia[i], 16'h0000, ie[i], i == 13);
  endtask
  task automatic t_config();
    acc(1'b0, ADDR_CONFIG, 16'h0000, 16'h0004, 1'b0);
    chk({7'h00, curve, slope, stg, cme, cto, cvto, fto}, 16'h0020);
    acc(1'b1, ADDR_CONFIG, 16'hffff, 16'h07cf, 1'b0);
    @(posedge clock);
    #1;
    chk({7'h00, curve, slope, stg, cme, cto, cvto, fto}, 16'h01ff);
    acc(1'b1, ADDR_CHARGE, 16'hffff, 16'h0000, 1'b1);
    acc(1'b1, ADDR_FAULT, 16'hffff, 16'h0000, 1'b1);
    acc(1'b0, ADDR_CONFIG, 16'h0000, 16'h07cf, 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      acc(1'b1, ADDR_CONFIG, 16'(16'h0780 | c * 5), 16'(16'h0780 | c * 5), 1'b0);
      @(posedge clock);
      #1;
      chk({12'h000, curve, slope}, 16'(c * 5));
    end
  endtask
  task automatic t_fault();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock);
      flt <= 7'(8'h01 << i);
      repeat (4) @(posedge clock);
      acc(1'b0, ADDR_FAULT, 16'h0000, {8'h00, 7'(8'h01 << i), 1'b0}, 1'b0);
    end
  endtask
  task automatic t_charge();
    @(posedge clock);
    chg <= 9'h1ff;
    repeat (4) @(posedge clock);
    acc(1'b0, ADDR_CHARGE, 16'h0000, 16'hec0f, 1'b0);
    acc(1'b1, ADDR_CONFIG, 16'h0080, 16'h0080, 1'b0);
    acc(1'b0, ADDR_CHARGE, 16'h0000, 16'h0c0f, 1'b0);
    acc(1'b1, ADDR_CONFIG, 16'h0004, 16'h0004, 1'b0);
    acc(1'b0, ADDR_CHARGE, 16'h0000, 16'h0000, 1'b0);
  endtask
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  initial
  begin
    reset_n = 1'b0;
    flt = 7'h00;
    chg = 9'h000;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    t_ident();
    t_config();
    t_fault();
    t_charge();
    give_verdict();
  end
endmodule
